// ==== core/fault_bank_pkg.sv ====
// Shared offsets, field positions, reset values and carriers of the fault bank
package fault_bank_pkg;

    localparam logic [5:0] OFS_IC_STATUS = 6'h00;
    localparam logic [5:0] OFS_STAT_ONE  = 6'h01;
    localparam logic [5:0] OFS_STAT_TWO  = 6'h02;
    localparam logic [5:0] OFS_CTRL_ONE  = 6'h03;
    localparam logic [5:0] OFS_CTRL_TWO  = 6'h04;
    localparam logic [5:0] OFS_CTRL_THR  = 6'h05;
    localparam logic [5:0] OFS_CTRL_FOUR = 6'h06;
    localparam logic [5:0] OFS_CTRL_FIVE = 6'h07;
    localparam logic [5:0] OFS_CTRL_SIX  = 6'h08;
    localparam logic [5:0] OFS_CTRL_TEN  = 6'h0C;
    localparam logic [5:0] OFS_LAST      = 6'h0C;

    // First status register bit positions
    localparam int POS_THERMAL_WARN = 7;
    localparam int POS_THERMAL_SHUT = 6;
    localparam int POS_C_HIGH       = 5;
    localparam int POS_C_LOW        = 4;
    localparam int POS_B_HIGH       = 3;
    localparam int POS_B_LOW        = 2;
    localparam int POS_A_HIGH       = 1;
    localparam int POS_A_LOW        = 0;

    // Second status register bit positions
    localparam int POS_OTP_ERROR    = 6;
    localparam int POS_REG_OVERCUR  = 5;
    localparam int POS_REG_UNDERV   = 4;
    localparam int POS_PUMP_LOW     = 3;
    localparam int POS_PARITY_ERR   = 2;
    localparam int POS_FRAMING_ERR  = 1;
    localparam int POS_BAD_ADDRESS  = 0;

    // Control fields
    localparam int POS_CLEAR_FAULTS = 0;
    localparam logic [2:0] LOCK_CODE_OPEN = 3'h3;
    localparam logic [2:0] LOCK_CODE_SHUT = 3'h6;

    localparam logic [7:0] RST_STATUS    = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO  = 8'h60;
    localparam logic [7:0] RST_CTRL_THR  = 8'h46;
    localparam logic [7:0] RST_CTRL_FOUR = 8'h10;
    localparam logic [7:0] RST_CTRL_FIVE = 8'h00;
    localparam logic [7:0] RST_CTRL_SIX  = 8'h00;
    localparam logic [7:0] RST_CTRL_TEN  = 8'h00;

    // Writable bits per control register; others read as zero
    localparam logic [7:0] WMASK_CTRL_ONE = 8'h07;
    localparam logic [7:0] WMASK_CTRL_TWO = 8'hFE;
    localparam logic [7:0] WMASK_CTRL_THR = 8'h7F;

    typedef struct packed {
        logic       read;
        logic [5:0] addr;
        logic       parity;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic thermal_warning_flag;
        logic thermal_shutdown_flag;
        logic phase_c_high_overcurrent;
        logic phase_c_low_overcurrent;
        logic phase_b_high_overcurrent;
        logic phase_b_low_overcurrent;
        logic phase_a_high_overcurrent;
        logic phase_a_low_overcurrent;
        logic otp_error_flag;
        logic regulator_overcurrent_flag;
        logic regulator_undervoltage_flag;
        logic charge_pump_low_flag;
    } detect_t;

    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
        logic [7:0] three;
        logic [7:0] four;
        logic [7:0] five;
        logic [7:0] six;
        logic [7:0] ten;
    } control_t;

    typedef enum logic [0:0] {
        LOCK_OPEN = 1'b0,
        LOCK_SHUT = 1'b1
    } lock_t;

endpackage

// ==== core/fault_status_register_bank.sv ====
// Fault status and control register bank behind a 16-bit serial frame port
`timescale 1ns/1ps

module fault_status_register_bank
    import fault_bank_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input  wire logic     clock,
    input  wire logic     rst,
    input  wire logic     sleep_reset,
    input  wire logic     frame_valid,
    input  wire logic     frame_abort,
    input  wire frame_t   frame,
    input  wire detect_t  detect,
    output logic [15:0]   reply_q,
    output logic          reply_valid_q,
    output control_t      control_q,
    output logic          regs_locked_q,
    output logic [7:0]    fault_status_one_q,
    output logic [7:0]    fault_status_two_q
);

    if (ADDR_W != 6) begin : g_bad_width
        $error("Frame address field is fixed at six bits");
    end

    // Even parity over the whole word
    function automatic logic parity_fails(input frame_t f);
        parity_fails = ^f;
    endfunction

    function automatic logic addr_invalid(input logic [5:0] a);
        addr_invalid = (a > OFS_LAST);
    endfunction

    lock_t       lock_q;
    lock_t       lock_d;
    control_t    control_d;
    logic        framing_q;
    logic        framing_d;
    logic        parity_q;
    logic        parity_d;
    logic        bad_addr_q;
    logic        bad_addr_d;
    logic [7:0]  stat_one_d;
    logic [7:0]  stat_two_d;
    logic [15:0] reply_d;
    logic        reply_valid_d;
    logic        frame_bad_par;
    logic        frame_bad_addr;
    logic        frame_write;
    logic        clear_cmd;
    logic [7:0]  read_value;

    // Write only on a clean frame; a damaged word must not touch settings
    assign frame_bad_par  = parity_fails(frame);
    assign frame_bad_addr = addr_invalid(frame.addr);
    assign frame_write    = frame_valid && !frame.read
                            && !frame_bad_par && !frame_bad_addr;

    // Lock also blocks the clear command, as it lives outside the lock field
    assign clear_cmd = frame_write && (lock_q == LOCK_OPEN)
                       && (frame.addr == OFS_CTRL_TWO)
                       && frame.data[POS_CLEAR_FAULTS];

    // Register contents before this frame's write, status read-only
    always_comb begin
        case (frame.addr)
            OFS_STAT_ONE:  read_value = fault_status_one_q;
            OFS_STAT_TWO:  read_value = fault_status_two_q;
            OFS_CTRL_ONE:  read_value = control_q.one;
            OFS_CTRL_TWO:  read_value = control_q.two;
            OFS_CTRL_THR:  read_value = control_q.three;
            OFS_CTRL_FOUR: read_value = control_q.four;
            OFS_CTRL_FIVE: read_value = control_q.five;
            OFS_CTRL_SIX:  read_value = control_q.six;
            OFS_CTRL_TEN:  read_value = control_q.ten;
            default:       read_value = 8'h00;
        endcase
    end

    // Latched link faults: a new event wins over a clear in the same cycle
    always_comb begin
        framing_d  = (framing_q && !clear_cmd) || frame_abort;
        parity_d   = (parity_q && !clear_cmd)
                     || (frame_valid && frame_bad_par);
        bad_addr_d = (bad_addr_q && !clear_cmd)
                     || (frame_valid && frame_bad_addr);
        if (sleep_reset) begin
            framing_d  = 1'b0;
            parity_d   = 1'b0;
            bad_addr_d = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            framing_q  <= 1'b0;
            parity_q   <= 1'b0;
            bad_addr_q <= 1'b0;
        end else begin
            framing_q  <= framing_d;
            parity_q   <= parity_d;
            bad_addr_q <= bad_addr_d;
        end
    end

    // Status images; detector bits are live levels, not latched
    always_comb begin
        stat_one_d = RST_STATUS;
        stat_one_d[POS_THERMAL_WARN] = detect.thermal_warning_flag;
        stat_one_d[POS_THERMAL_SHUT] = detect.thermal_shutdown_flag;
        stat_one_d[POS_C_HIGH] = detect.phase_c_high_overcurrent;
        stat_one_d[POS_C_LOW]  = detect.phase_c_low_overcurrent;
        stat_one_d[POS_B_HIGH] = detect.phase_b_high_overcurrent;
        stat_one_d[POS_B_LOW]  = detect.phase_b_low_overcurrent;
        stat_one_d[POS_A_HIGH] = detect.phase_a_high_overcurrent;
        stat_one_d[POS_A_LOW]  = detect.phase_a_low_overcurrent;
        // Bit 7 stays at its zero default
        stat_two_d = RST_STATUS;
        stat_two_d[POS_OTP_ERROR]   = detect.otp_error_flag;
        stat_two_d[POS_REG_OVERCUR] =
            detect.regulator_overcurrent_flag;
        stat_two_d[POS_REG_UNDERV]  =
            detect.regulator_undervoltage_flag;
        stat_two_d[POS_PUMP_LOW]    = detect.charge_pump_low_flag;
        stat_two_d[POS_PARITY_ERR]  = parity_q;
        stat_two_d[POS_FRAMING_ERR] = framing_q;
        stat_two_d[POS_BAD_ADDRESS] = bad_addr_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_status_one_q <= RST_STATUS;
            fault_status_two_q <= RST_STATUS;
        end else begin
            fault_status_one_q <= stat_one_d;
            fault_status_two_q <= stat_two_d;
        end
    end

    // Control registers and the password lock
    always_comb begin
        control_d = control_q;
        lock_d    = lock_q;
        if (frame_write && frame.addr == OFS_CTRL_ONE) begin
            case (frame.data[2:0])
                LOCK_CODE_OPEN: begin
                    lock_d        = LOCK_OPEN;
                    control_d.one = frame.data & WMASK_CTRL_ONE;
                end
                LOCK_CODE_SHUT: begin
                    lock_d        = LOCK_SHUT;
                    control_d.one = frame.data & WMASK_CTRL_ONE;
                end
                default: begin
                    lock_d = lock_q;
                end
            endcase
        end else if (frame_write && lock_q == LOCK_OPEN) begin
            case (frame.addr)
                // Clear bit never stored, so it reads back zero
                OFS_CTRL_TWO:  control_d.two =
                    frame.data & WMASK_CTRL_TWO;
                OFS_CTRL_THR:  control_d.three =
                    frame.data & WMASK_CTRL_THR;
                OFS_CTRL_FOUR: control_d.four = frame.data;
                OFS_CTRL_FIVE: control_d.five = frame.data;
                OFS_CTRL_SIX:  control_d.six  = frame.data;
                OFS_CTRL_TEN:  control_d.ten  = frame.data;
                // Reserved and status offsets take no write
                default:       control_d = control_q;
            endcase
        end
        if (sleep_reset) begin
            lock_d    = LOCK_OPEN;
            control_d = '{RST_CTRL_ONE, RST_CTRL_TWO, RST_CTRL_THR,
                          RST_CTRL_FOUR, RST_CTRL_FIVE, RST_CTRL_SIX,
                          RST_CTRL_TEN};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_q    <= LOCK_OPEN;
            control_q <= '{RST_CTRL_ONE, RST_CTRL_TWO, RST_CTRL_THR,
                           RST_CTRL_FOUR, RST_CTRL_FIVE, RST_CTRL_SIX,
                           RST_CTRL_TEN};
        end else begin
            lock_q    <= lock_d;
            control_q <= control_d;
        end
    end

    // Reply: status byte then the register's contents before any write
    always_comb begin
        reply_valid_d = frame_valid;
        reply_d       = reply_q;
        if (frame_valid) begin
            reply_d = {fault_status_two_q, read_value};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reply_q       <= 16'h0000;
            reply_valid_q <= 1'b0;
            regs_locked_q <= 1'b0;
        end else begin
            reply_q       <= reply_d;
            reply_valid_q <= reply_valid_d;
            regs_locked_q <= (lock_d == LOCK_SHUT);
        end
    end

endmodule

// ==== verif/fault_bank_assertions.sv ====
// Port-level assertions of the fault status register bank
`timescale 1ns/1ps
module fault_bank_assertions
    import fault_bank_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        sleep_reset,
    input wire logic        frame_valid,
    input wire logic        frame_abort,
    input wire frame_t      frame,
    input wire detect_t     detect,
    input wire logic [15:0] reply_q,
    input wire logic        reply_valid_q,
    input wire control_t    control_q,
    input wire logic        regs_locked_q,
    input wire logic [7:0]  fault_status_one_q,
    input wire logic [7:0]  fault_status_two_q
);
    wire logic wr_ok;
    wire logic clr;
    assign wr_ok = frame_valid && !frame.read && !(^frame);
    assign clr = wr_ok && frame.addr == OFS_CTRL_TWO && frame.data[0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_detect_live_bits: assert property (
        !$past(rst) && !$past(sleep_reset) |->
        {fault_status_one_q, fault_status_two_q[6:3]} == $past(detect))
        else $error("live status bits off");
    a_read_stat_one: assert property (
        frame_valid && frame.read && frame.addr == OFS_STAT_ONE && !(^frame)
        |=> reply_q[7:0] == $past(fault_status_one_q))
        else $error("status one read wrong");
    a_reserved_zero: assert property (
        !fault_status_two_q[7] && !control_q.two[POS_CLEAR_FAULTS])
        else $error("reserved or clear bit set");
    a_abort_flag: assert property (
        frame_abort && !sleep_reset |-> ##[1:2] fault_status_two_q[1])
        else $error("framing flag missing");
    a_parity_flag: assert property (
        frame_valid && ^frame && !sleep_reset |-> ##[1:2] fault_status_two_q[2])
        else $error("parity flag missing");
    a_bad_address: assert property (
        frame_valid && frame.addr > OFS_LAST && !sleep_reset
        |=> reply_q[7:0] == 8'h00 ##[0:1] fault_status_two_q[0])
        else $error("bad address not flagged");
    a_latch_hold: assert property (
        $fell(fault_status_two_q[0]) || $fell(fault_status_two_q[1])
        || $fell(fault_status_two_q[2]) |-> $past(clr) || $past(clr, 2)
        || $past(sleep_reset) || $past(sleep_reset, 2))
        else $error("latched flag dropped");
    a_clear_works: assert property (
        clr && !regs_locked_q && !frame_abort
        |-> ##[1:2] fault_status_two_q[2:0] == 3'h0)
        else $error("clear left flags");
    a_lock_hold: assert property (
        regs_locked_q && wr_ok && frame.addr == OFS_CTRL_FOUR && !sleep_reset
        |=> $stable(control_q.four))
        else $error("locked write took effect");
endmodule

// ==== verif/link_host_model.sv ====
// Serial port controller model issuing whole or short frames
`timescale 1ns/1ps
module link_host_model
    import fault_bank_pkg::*;
(
    input  wire logic clock,
    output logic      frame_valid,
    output logic      frame_abort,
    output frame_t    frame
);
    initial begin
        frame_valid = 1'b0;
        frame_abort = 1'b0;
        frame = '0;
    end
    // Even parity unless bad is set; offsets come from the caller
    task automatic send(input logic rd, input logic [5:0] a,
                        input logic [7:0] d, input logic bad);
        @(posedge clock) #1 frame = '{rd, a, 1'b0, d};
        frame.parity = ^frame ^ bad;
        frame_valid = 1'b1;
        @(posedge clock) #1 frame_valid = 1'b0;
        // Stale word inverted so nothing leans on a held value
        frame = ~frame;
    endtask
    task automatic abort();
        @(posedge clock) #1 frame_abort = 1'b1;
        @(posedge clock) #1 frame_abort = 1'b0;
    endtask
endmodule

// ==== verif/fault_status_register_bank_test.sv ====
// Self-checking bench of the fault status register bank
`timescale 1ns/1ps
module fault_status_register_bank_test;
    import fault_bank_pkg::*;
    logic        clock, rst, sleep_reset, frame_valid, frame_abort;
    logic        reply_valid_q, regs_locked_q;
    logic [7:0]  fault_status_one_q, fault_status_two_q;
    logic [15:0] reply_q, r;
    logic [31:0] seed = 32'h8;
    logic [5:0]  ofs [4];
    frame_t      frame;
    detect_t     detect;
    control_t    control_q;
    int          mismatches, total_checks, cycles;

    fault_status_register_bank uut (
        .clock(clock), .rst(rst), .sleep_reset(sleep_reset),
        .frame_valid(frame_valid), .frame_abort(frame_abort),
        .frame(frame), .detect(detect), .reply_q(reply_q),
        .reply_valid_q(reply_valid_q), .control_q(control_q),
        .regs_locked_q(regs_locked_q),
        .fault_status_one_q(fault_status_one_q),
        .fault_status_two_q(fault_status_two_q));
    link_host_model host (.clock(clock), .frame_valid(frame_valid),
        .frame_abort(frame_abort), .frame(frame));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] two_live(input detect_t d);
        return {1'b0, d.otp_error_flag, d.regulator_overcurrent_flag,
            d.regulator_undervoltage_flag, d.charge_pump_low_flag, 3'h0};
    endfunction
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [5:0] a,
                        input logic [7:0] d, input logic bad);
        host.send(rd, a, d, bad);
        r = reply_q;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // About 122 cycles are needed; the ceiling only catches a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1;
        sleep_reset = 1'b0;
        detect = '0;
        ofs = '{OFS_CTRL_FOUR, OFS_CTRL_FIVE, OFS_CTRL_SIX, OFS_CTRL_TEN};
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        check(control_q, 56'h00604610000000);
        check({fault_status_one_q, fault_status_two_q}, 16'h0);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            detect = (i == 0) ? 12'hFFF : detect_t'(seed[11:0]);
            xfer(1'b1, OFS_STAT_ONE, 8'h00, 1'b0);
            check(r, {two_live(detect), detect[11:4]});
            xfer(1'b1, OFS_STAT_TWO, 8'h00, 1'b0);
            check(r[7:0], two_live(detect));
        end
        detect = '0;
        host.abort();
        xfer(1'b1, 6'h0D, 8'h00, 1'b0);
        check(r[7:0], 8'h00);
        xfer(1'b0, OFS_CTRL_FOUR, 8'h5A, 1'b1);
        xfer(1'b1, OFS_CTRL_FOUR, 8'h00, 1'b0);
        check(r, 16'h0710);
        // Zero in the clear bit must leave every latched flag alone
        xfer(1'b0, OFS_CTRL_TWO, 8'h60, 1'b0);
        xfer(1'b1, OFS_STAT_TWO, 8'h00, 1'b0);
        check(r, 16'h0707);
        xfer(1'b0, OFS_CTRL_TWO, 8'hA5, 1'b0);
        xfer(1'b1, OFS_CTRL_TWO, 8'h00, 1'b0);
        check(r, 16'h00A4);
        xfer(1'b0, OFS_CTRL_ONE, 8'h06, 1'b0);
        xfer(1'b0, OFS_CTRL_FOUR, 8'h5A, 1'b0);
        xfer(1'b0, OFS_CTRL_ONE, 8'h05, 1'b0);
        xfer(1'b1, OFS_CTRL_FOUR, 8'h00, 1'b0);
        check({regs_locked_q, r[7:0]}, 9'h110);
        xfer(1'b0, OFS_CTRL_ONE, 8'hFB, 1'b0);
        xfer(1'b1, OFS_CTRL_ONE, 8'h00, 1'b0);
        check({regs_locked_q, r[7:0]}, 9'h003);
        foreach (ofs[k]) begin
            seed = xs(seed);
            xfer(1'b0, ofs[k], seed[7:0], 1'b0);
            xfer(1'b1, ofs[k], 8'h00, 1'b0);
            check(r[7:0], seed[7:0]);
        end
        host.abort();
        @(posedge clock) #1 sleep_reset = 1'b1;
        @(posedge clock) #1 sleep_reset = 1'b0;
        xfer(1'b1, OFS_STAT_TWO, 8'h00, 1'b0);
        check(r, 16'h0);
        check(control_q, 56'h00604610000000);
        final_report();
    end
endmodule

bind fault_status_register_bank fault_bank_assertions
    #(.ADDR_W(ADDR_W)) chk (
    .clock(clock), .rst(rst), .sleep_reset(sleep_reset),
    .frame_valid(frame_valid), .frame_abort(frame_abort),
    .frame(frame), .detect(detect), .reply_q(reply_q),
    .reply_valid_q(reply_valid_q), .control_q(control_q),
    .regs_locked_q(regs_locked_q),
    .fault_status_one_q(fault_status_one_q),
    .fault_status_two_q(fault_status_two_q));
